// file: hdl/synth_div_pkg.sv
// Shared constants, types and register map of the synthesizer post-divider outputs.
`default_nettype none
package synth_div_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  DIV_A_BASE     = 8'h80;
  localparam logic [7:0]  DIV_B_BASE     = 8'h83;
  localparam logic [7:0]  CFG_BYTES      = 8'h03;
  localparam logic [23:0] CFG_RESET      = 24'h000002;
  localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [3:0]  MODE_SPECIAL   = 4'hF;
  localparam logic [1:0]  LOW_CODE_A     = 2'h0;
  localparam logic [1:0]  LOW_CODE_B     = 2'h1;
  localparam logic        STYLE_MIDDLE   = 1'h0;
  localparam logic        STYLE_FIRST    = 1'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  mode;
    logic        style;
    logic        polarity;
    logic [1:0]  source;
    logic [15:0] rate;
  } cfg_type;

  typedef enum logic [1:0] {
    MODE_DIV   = 2'h0,
    MODE_LOW   = 2'h1,
    MODE_FRAME = 2'h3
  } mode_type;

endpackage
`default_nettype wire

// file: hdl/post_divider.sv
// One post-divider: divided clock, low-frequency clock or frame pulse.
`default_nettype none
module post_divider
  import synth_div_pkg::*;
#(
  parameter logic [1:0] LOW_CODE = LOW_CODE_A
)
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire cfg_type    i_cfg,
  input  wire logic       i_base_tick,
  input  wire logic [3:0] i_ref_ticks,
  output var  logic       o_out,
  output var  logic       o_period_tick
);

  // ****************************************************************
  // Decode and change tracking
  // ****************************************************************
  mode_type    mode_reg;
  mode_type    mode_next;
  cfg_type     cfg_prev_reg;
  logic        cfg_changed;
  logic [23:0] ratio;
  logic [23:0] ratio_m1;
  logic [23:0] half_ratio;
  logic [15:0] rate_m1;
  logic [23:0] cnt_reg;
  logic [23:0] elapsed_reg;
  logic [23:0] half_reg;
  logic        ref_tick;
  logic        active;

  assign cfg_changed = (cfg_prev_reg != i_cfg);
  assign ratio       = i_cfg;
  assign ratio_m1    = (ratio == 24'h000000) ? 24'h000000 : ratio - 24'h000001;
  assign half_ratio  = 24'((25'(ratio) + 25'h0000001) >> 1);
  assign rate_m1     = (i_cfg.rate == 16'h0000) ? 16'h0000 : i_cfg.rate - 16'h0001;
  assign ref_tick    = i_ref_ticks[i_cfg.source];

  always_comb
  begin
    if (i_cfg.mode != MODE_SPECIAL)
      mode_next = MODE_DIV;
    else if (i_cfg.source == LOW_CODE)
      mode_next = MODE_LOW;
    else
      mode_next = MODE_FRAME;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      mode_reg     <= MODE_DIV;
      cfg_prev_reg <= CFG_RESET;
    end
    else
    begin
      mode_reg     <= mode_next;
      cfg_prev_reg <= i_cfg;
    end
  end

  // ****************************************************************
  // Frame boundary placement
  // ****************************************************************
  // The reference period is re-measured at every reference tick so the middle-style pulse can
  // straddle the boundary; the first frame after a change uses a stale half.
  always_comb
  begin
    if (i_cfg.style == STYLE_FIRST)
      active = (cnt_reg[15:0] == 16'h0000);
    else
      active = ((cnt_reg[15:0] == rate_m1) && (elapsed_reg >= half_reg)) ||
               ((cnt_reg[15:0] == 16'h0000) && (elapsed_reg < half_reg));
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      elapsed_reg <= 24'h000000;
      half_reg    <= 24'h000000;
    end
    else if (ref_tick)
    begin
      elapsed_reg <= 24'h000000;
      half_reg    <= 24'((25'(elapsed_reg) + 25'h0000001) >> 1);
    end
    else
      elapsed_reg <= elapsed_reg + 24'h000001;
  end

  // ****************************************************************
  // Counter and output
  // ****************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt_reg       <= 24'h000000;
      o_out         <= 1'b0;
      o_period_tick <= 1'b0;
    end
    else if (cfg_changed)
    begin
      cnt_reg       <= 24'h000000;
      o_out         <= 1'b0;
      o_period_tick <= 1'b0;
    end
    else
    begin
      unique case (mode_reg)
        MODE_DIV:
        begin
          cnt_reg       <= (cnt_reg >= ratio_m1) ? 24'h000000 : cnt_reg + 24'h000001;
          o_out         <= (cnt_reg < half_ratio);
          o_period_tick <= (cnt_reg == 24'h000000);
        end
        MODE_LOW:
        begin
          o_period_tick <= 1'b0;
          if (i_base_tick)
          begin
            if (cnt_reg[15:0] >= rate_m1)
            begin
              cnt_reg       <= 24'h000000;
              o_out         <= !o_out;
              o_period_tick <= !o_out;
            end
            else
              cnt_reg <= cnt_reg + 24'h000001;
          end
        end
        MODE_FRAME:
        begin
          if (ref_tick)
            cnt_reg <= (cnt_reg[15:0] >= rate_m1) ? 24'h000000 : cnt_reg + 24'h000001;
          o_out         <= active ^ i_cfg.polarity;
          o_period_tick <= ref_tick && (cnt_reg[15:0] == rate_m1);
        end
        default:
        begin
          cnt_reg       <= 24'h000000;
          o_out         <= 1'b0;
          o_period_tick <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_div_mode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_cfg.mode != MODE_SPECIAL) |=> (mode_reg == MODE_DIV);
  endproperty
  a_div_mode: assert property (p_div_mode) else $error("Non-special mode not divided clock.");

  property p_frame_mode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_cfg.mode == MODE_SPECIAL) && (i_cfg.source != LOW_CODE) |=> (mode_reg == MODE_FRAME);
  endproperty
  a_frame_mode: assert property (p_frame_mode) else $error("Frame mode not selected.");

  property p_div_wrap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (mode_reg == MODE_DIV) && !cfg_changed && (cnt_reg == ratio_m1) && (ratio > 24'h000001)
      ##1 !cfg_changed |-> (cnt_reg == 24'h000000) ##1 o_out;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("Divided clock did not restart high.");

  property p_low_toggle;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (mode_reg == MODE_LOW) && !cfg_changed && i_base_tick && (cnt_reg[15:0] >= rate_m1)
      |=> (o_out != $past(o_out)) || $past(cfg_changed);
  endproperty
  a_low_toggle: assert property (p_low_toggle) else $error("Low clock missed its toggle.");

  property p_first_edge;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (mode_reg == MODE_FRAME) && !cfg_changed && (i_cfg.style == STYLE_FIRST) && ref_tick &&
      (cnt_reg[15:0] == rate_m1) ##1 !cfg_changed
      |-> ##1 (o_out == !$past(i_cfg.polarity));
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("Frame pulse not at boundary.");

  property p_spacing;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (mode_reg == MODE_FRAME) && !cfg_changed && ref_tick && (cnt_reg[15:0] < rate_m1)
      |=> (cnt_reg == $past(cnt_reg) + 24'h000001) || $past(cfg_changed);
  endproperty
  a_spacing: assert property (p_spacing) else $error("Frame spacing count skipped.");

  c_low: cover property (@(posedge i_clk_sys) (mode_reg == MODE_LOW) && $rose(o_out));
  c_frame: cover property (@(posedge i_clk_sys) (mode_reg == MODE_FRAME) && o_period_tick);
  c_div: cover property (@(posedge i_clk_sys) (mode_reg == MODE_DIV) && $rose(o_out));

endmodule
`default_nettype wire

// file: hdl/synth_post_divider_output.sv
// Post-dividers A and B of the first synthesizer with their byte register port.
`default_nettype none

module synth_post_divider_output
  import synth_div_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_base_tick,
  input  wire logic       i_ref_c_tick,
  input  wire logic       i_ref_d_tick,
  output var  logic [7:0] o_reg_rdata,
  output var  logic       o_out_a,
  output var  logic       o_out_b
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // The port sees full eight-bit addresses; paging of the seven-bit serial
  // address is resolved before this block, so 0x80 upward arrives here intact.
  cfg_type    synth0_divider_a_config_reg;
  cfg_type    synth0_divider_b_config_reg;
  logic [7:0] offs_a;
  logic [7:0] offs_b;
  logic       hit_a;
  logic       hit_b;
  logic [1:0] lane_a;
  logic [1:0] lane_b;
  logic [7:0] rdata_next;
  logic       tick_a;
  logic       tick_b;
  logic [3:0] refs_a;
  logic [3:0] refs_b;

  assign offs_a = i_reg_addr - DIV_A_BASE;
  assign offs_b = i_reg_addr - DIV_B_BASE;
  assign hit_a  = (i_reg_addr >= DIV_A_BASE) && (offs_a < CFG_BYTES);
  assign hit_b  = (i_reg_addr >= DIV_B_BASE) && (offs_b < CFG_BYTES);
  assign lane_a = offs_a[1:0];
  assign lane_b = offs_b[1:0];

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      synth0_divider_a_config_reg <= CFG_RESET;
    else if (i_reg_wr && hit_a)
      synth0_divider_a_config_reg[lane_a * 8 +: 8] <= i_reg_wdata;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      synth0_divider_b_config_reg <= CFG_RESET;
    else if (i_reg_wr && hit_b)
      synth0_divider_b_config_reg[lane_b * 8 +: 8] <= i_reg_wdata;
  end

  always_comb
  begin
    if (hit_a)
      rdata_next = synth0_divider_a_config_reg[lane_a * 8 +: 8];
    else if (hit_b)
      rdata_next = synth0_divider_b_config_reg[lane_b * 8 +: 8];
    else
      rdata_next = RDATA_UNMAPPED;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_reg_rdata <= RDATA_UNMAPPED;
    else
      o_reg_rdata <= rdata_next;
  end

  // ****************************************************************
  // Divider instances
  // ****************************************************************
  // Each divider publishes one tick per output period, which the other one can
  // use as its pulse-width reference. The slot of a divider's own low-frequency
  // code is never selected as a reference and stays low.
  assign refs_a = {i_ref_d_tick, i_ref_c_tick, tick_b, 1'b0};
  assign refs_b = {i_ref_d_tick, i_ref_c_tick, 1'b0, tick_a};

  post_divider #(
    .LOW_CODE (LOW_CODE_A)
  ) u_div_a (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .i_cfg         (synth0_divider_a_config_reg),
    .i_base_tick   (i_base_tick),
    .i_ref_ticks   (refs_a),
    .o_out         (o_out_a),
    .o_period_tick (tick_a)
  );

  post_divider #(
    .LOW_CODE (LOW_CODE_B)
  ) u_div_b (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .i_cfg         (synth0_divider_b_config_reg),
    .i_base_tick   (i_base_tick),
    .i_ref_ticks   (refs_b),
    .o_out         (o_out_b),
    .o_period_tick (tick_b)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_b_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.mode == MODE_SPECIAL) &&
      (synth0_divider_b_config_reg.source == LOW_CODE_B) |=> (u_div_b.mode_reg == MODE_LOW);
  endproperty
  a_b_low: assert property (p_b_low) else $error("Divider B code 01 not low clock.");

  property p_b_ref_a;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.source == 2'h0) |-> (u_div_b.ref_tick == tick_a);
  endproperty
  a_b_ref_a: assert property (p_b_ref_a) else $error("Divider B not referenced to A.");

  property p_b_ref_c;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.source == 2'h2) |-> (u_div_b.ref_tick == i_ref_c_tick);
  endproperty
  a_b_ref_c: assert property (p_b_ref_c) else $error("Divider B not referenced to C.");

  property p_ratio_bits;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (u_div_a.mode_reg == MODE_DIV) && !u_div_a.cfg_changed && (u_div_a.cnt_reg != 24'h000000)
      ##1 !u_div_a.cfg_changed && (u_div_a.cnt_reg == 24'h000000)
      |-> ($past(u_div_a.cnt_reg) == 24'(synth0_divider_a_config_reg) - 24'h000001);
  endproperty
  a_ratio_bits: assert property (p_ratio_bits) else $error("Ratio lost its upper bits.");

  property p_write_b;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_reg_wr && (i_reg_addr == DIV_B_BASE) |=>
      (synth0_divider_b_config_reg.rate[7:0] == $past(i_reg_wdata));
  endproperty
  a_write_b: assert property (p_write_b) else $error("Write to divider B byte lost.");

  // Divider internals are probed by hierarchy so that the mapping of source codes
  // to companions is checked where each divider picks its reference.
  property p_b_ref_d;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.source == 2'h3) |-> (u_div_b.ref_tick == i_ref_d_tick);
  endproperty
  a_b_ref_d: assert property (p_b_ref_d) else $error("Divider B not referenced to D.");

  property p_a_ref_b;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_a_config_reg.source == 2'h1) |-> (u_div_a.ref_tick == tick_b);
  endproperty
  a_a_ref_b: assert property (p_a_ref_b) else $error("Divider A not referenced to B.");

  property p_a_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_a_config_reg.mode == MODE_SPECIAL) &&
      (synth0_divider_a_config_reg.source == LOW_CODE_A) |=> (u_div_a.mode_reg == MODE_LOW);
  endproperty
  a_a_low: assert property (p_a_low) else $error("Divider A code 00 not low clock.");

  property p_b_div;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.mode != MODE_SPECIAL) |=> (u_div_b.mode_reg == MODE_DIV);
  endproperty
  a_b_div: assert property (p_b_div) else $error("Divider B source bits chose a mode.");

  property p_a_div;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_a_config_reg.mode != MODE_SPECIAL) |=> (u_div_a.mode_reg == MODE_DIV);
  endproperty
  a_a_div: assert property (p_a_div) else $error("Divider A style bit chose a mode.");

  property p_b_frame;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (synth0_divider_b_config_reg.mode == MODE_SPECIAL) &&
      (synth0_divider_b_config_reg.source != LOW_CODE_B) |=> (u_div_b.mode_reg == MODE_FRAME);
  endproperty
  a_b_frame: assert property (p_b_frame) else $error("Divider B frame code not framed.");

  property p_b_polarity;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (u_div_b.mode_reg == MODE_FRAME) && !u_div_b.cfg_changed && !u_div_b.active
      |=> (o_out_b == $past(synth0_divider_b_config_reg.polarity));
  endproperty
  a_b_polarity: assert property (p_b_polarity) else $error("Frame idle level wrong.");

  property p_b_low_steady;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (u_div_b.mode_reg == MODE_LOW) && !u_div_b.cfg_changed && !i_base_tick
      |=> $stable(o_out_b);
  endproperty
  a_b_low_steady: assert property (p_b_low_steady) else $error("Low clock moved.");

  c_write_a: cover property (@(posedge i_clk_sys) i_reg_wr && hit_a);
  c_b_frame: cover property (@(posedge i_clk_sys) (u_div_b.mode_reg == MODE_FRAME) && tick_b);

endmodule
`default_nettype wire

// file: verif/ref_tick_model.sv
// Behavioural source of the base-rate tick and of the companion C and D tick trains.
`default_nettype none
module ref_tick_model
#(
  parameter int BASE_DIV = 5,
  parameter int C_DIV    = 8,
  parameter int D_DIV    = 6
)
(
  input  wire logic i_clk_sys,
  output var  logic o_base_tick,
  output var  logic o_ref_c_tick,
  output var  logic o_ref_d_tick
);
  timeunit 1ns;
  timeprecision 100ps;

  // Periods differ pairwise, so a wrong reference choice shows up in the pulse counts.
  int cnt_base = 0;
  int cnt_c    = 0;
  int cnt_d    = 0;

  initial
  begin
    o_base_tick  = 1'b0;
    o_ref_c_tick = 1'b0;
    o_ref_d_tick = 1'b0;
  end

  always @(posedge i_clk_sys)
  begin
    #1;
    cnt_base = (cnt_base + 1) % BASE_DIV;
    cnt_c = (cnt_c + 1) % C_DIV;
    cnt_d = (cnt_d + 1) % D_DIV;
    o_base_tick = (cnt_base == 0);
    o_ref_c_tick = (cnt_c == 0);
    o_ref_d_tick = (cnt_d == 0);
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking testbench for the synthesizer post-divider outputs.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import synth_div_pkg::*;

  logic       clk_sys   = 1'b0;
  logic       rst_n     = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic       reg_wr    = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       base_tick;
  logic       ref_c_tick;
  logic       ref_d_tick;
  logic [7:0] reg_rdata;
  logic       out_a;
  logic       out_b;
  int         n_errors  = 0;
  int         cmp_count = 0;

  synth_post_divider_output synth_post_divider_output_i (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_base_tick(base_tick), .i_ref_c_tick(ref_c_tick),
    .i_ref_d_tick(ref_d_tick), .o_reg_rdata(reg_rdata), .o_out_a(out_a), .o_out_b(out_b));

  ref_tick_model #(.BASE_DIV(5), .C_DIV(8), .D_DIV(6)) ref_tick_model_i (
    .i_clk_sys(clk_sys), .o_base_tick(base_tick), .o_ref_c_tick(ref_c_tick),
    .o_ref_d_tick(ref_d_tick));

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Upper byte goes last, since each byte is live as soon as it lands.
  task automatic wr_cfg(input logic [7:0] base, input logic [23:0] val);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_sys);
      #1;
      reg_addr = base + k[7:0];
      reg_wr = 1'b1;
      reg_wdata = val[8*k +: 8];
    end
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    @(posedge clk_sys);
    #1;
    check(reg_rdata, exp);
  endtask

  // Counts high cycles and rising edges over n cycles; off is D-tick phase at first rise.
  task automatic measure(input logic sel_b, input int n, output int highs, output int rises,
                         output int off);
    logic prev;
    logic cur;
    int   since;
    repeat (100) @(posedge clk_sys);
    highs = 0;
    rises = 0;
    off = -1;
    since = -1000;
    @(negedge clk_sys);
    prev = sel_b ? out_b : out_a;
    repeat (n)
    begin
      @(negedge clk_sys);
      since = ref_d_tick ? 0 : since + 1;
      cur = sel_b ? out_b : out_a;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        rises++;
        if (off < 0 && since >= 0)
          off = since;
      end
      highs += (cur === 1'b1);
      prev = cur;
    end
  endtask

  task automatic run_mode(input logic sel_b, input logic [23:0] cfg, input int n,
                          input int exp_highs, input int exp_rises, output int off);
    int highs;
    int rises;
    wr_cfg(sel_b ? DIV_B_BASE : DIV_A_BASE, cfg);
    measure(sel_b, n, highs, rises, off);
    check(highs, exp_highs);
    check(rises, exp_rises);
  endtask

  task automatic t_reset;
    int off;
    for (int k = 0; k < 6; k++)
      rd_check(8'h80 + k[7:0], (k % 3 == 0) ? 8'h02 : 8'h00);
    rd_check(8'h86, 8'h00);
    rd_check(8'h7F, 8'h00);
    wr_cfg(8'h86, 24'h0000FF);
    rd_check(8'h86, 8'h00);
    rd_check(8'h88, 8'h00);
    measure(1'b0, 40, off, off, off);
    run_mode(1'b0, 24'h000002, 40, 20, 20, off);
    $display("Test reset values done");
  endtask

  task automatic t_regs;
    wr_cfg(DIV_A_BASE, 24'h123456);
    wr_cfg(DIV_B_BASE, 24'hABCDEF);
    rd_check(8'h80, 8'h56);
    rd_check(8'h81, 8'h34);
    rd_check(8'h82, 8'h12);
    rd_check(8'h83, 8'hEF);
    rd_check(8'h84, 8'hCD);
    rd_check(8'h85, 8'hAB);
    $display("Test register access done");
  endtask

  task automatic t_divide;
    int off;
    run_mode(1'b0, 24'h000004, 40, 20, 10, off);
    run_mode(1'b0, 24'h000005, 50, 30, 10, off);
    run_mode(1'b1, 24'h0F0003, 300, 300, 0, off);
    $display("Test regular divide done");
  endtask

  task automatic t_low;
    int off;
    run_mode(1'b0, 24'hF00003, 300, 150, 10, off);
    run_mode(1'b1, 24'hF10002, 300, 150, 15, off);
    $display("Test low-frequency clock done");
  endtask

  task automatic t_frame;
    int off;
    int off0;
    int off1;
    wr_cfg(DIV_A_BASE, 24'h000004);
    run_mode(1'b1, 24'hF00003, 120, 40, 10, off);
    run_mode(1'b1, 24'hF20004, 320, 80, 10, off);
    run_mode(1'b1, 24'hF60004, 320, 240, 10, off);
    run_mode(1'b1, 24'hF30004, 240, 60, 10, off0);
    run_mode(1'b1, 24'hFB0004, 240, 60, 10, off1);
    check((off0 - off1 + 6) % 6, 3);
    wr_cfg(DIV_B_BASE, 24'h000006);
    run_mode(1'b0, 24'hF10003, 180, 60, 10, off);
    $display("Test frame pulse done");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run;
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_divide;
    t_low;
    t_frame;
    complete_run;
  end
endmodule
`default_nettype wire
